// file: core/rsc_fifo.sv
// byte fifo between the line editor and the command parser.
// same clock on both sides; read data always come from a register.
`timescale 1ns/1ps
module rsc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic [$clog2(DEPTH+1)-1:0] level_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [CW-1:0] cnt_q;
    wire push = in_valid_i & in_ready_o;
    wire load = (cnt_q != '0) & (~out_valid_o | out_ready_i);

    assign in_ready_o = (cnt_q != CW'(DEPTH));
    assign level_o = cnt_q;

    always_ff @(posedge clk_i) begin
        if (push && ce_i) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end else if (ce_i) begin
            if (push) begin
                wr_q <= AW'((wr_q + 1'b1) % DEPTH);
            end
            if (load) begin
                rd_q <= AW'((rd_q + 1'b1) % DEPTH);
                out_data_o <= mem_q[rd_q];
            end
            cnt_q <= cnt_q + CW'(push) - CW'(load);
            if (load) begin
                out_valid_o <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
        end
    end

    fifo_bound_a: assert property (@(posedge clk_i) disable iff (reset_i)
        cnt_q <= CW'(DEPTH)) else $error("fifo count above depth");
endmodule

// file: core/rsc_link.sv
// serial command link of a rack: receives ascii lines, edits them,
// filters by rack address and hands decoded commands to the rack logic.
// assumes responses come from rack logic on the same clock.
`timescale 1ns/1ps
module rsc_link #(
    parameter int BIT_CYCLES = rsc_pkg::BIT_CYC,
    parameter int FLASH_CYCLES = rsc_pkg::FLASH_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic rxd_i,
    input wire logic cts_i,
    output logic txd_o,
    output logic rts_o,
    input wire logic old_fw_i,
    input wire logic [3:0] bus_switch_i,
    output logic [3:0] bus_addr_o,
    input wire logic [4:0] nv_addr_i,
    output logic nv_wr_o,
    input wire logic [4:0] panel_addr_i,
    input wire logic panel_addr_we_i,
    output logic [4:0] unit_addr_o,
    output logic cmd_valid_o,
    input wire logic cmd_ready_i,
    output logic [7:0] cmd_letter_o,
    output logic [7:0] cmd_chan_o,
    output logic [7:0] cmd_sel_o,
    output logic cmd_sel_valid_o,
    output logic cmd_query_o,
    output logic cmd_global_o,
    input wire logic resp_valid_i,
    input wire logic [7:0] resp_data_i,
    input wire logic resp_last_i,
    output logic resp_ready_o,
    output logic eoi_o,
    output logic led_flash_o
);
    import rsc_pkg::*;
    localparam int LW = $clog2(FIFO_DEPTH + 1);

    // pin synchronisers
    logic rxd_s1_q, rxd_s2_q, cts_s1_q, cts_s2_q;
    logic [3:0] sw_s1_q, sw_s2_q;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rxd_s1_q <= 1'b1;
            rxd_s2_q <= 1'b1;
            cts_s1_q <= 1'b0;
            cts_s2_q <= 1'b0;
            sw_s1_q <= '0;
            sw_s2_q <= '0;
        end else if (ce_i) begin
            rxd_s1_q <= rxd_i;
            rxd_s2_q <= rxd_s1_q;
            cts_s1_q <= cts_i;
            cts_s2_q <= cts_s1_q;
            sw_s1_q <= bus_switch_i;
            sw_s2_q <= sw_s1_q;
        end
    end

    logic [7:0] rx_data;
    logic rx_valid;
    rsc_uart_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .rxd_i(rxd_s2_q),
        .data_o(rx_data),
        .valid_o(rx_valid)
    );

    // line editor: one character is held back so a backspace can undo it
    logic [7:0] hold_q, end_byte_q, len_q;
    logic hold_v_q, end_pend_q, ovf_q;
    wire [7:0] line_max = old_fw_i ? 8'(LINE_MAX_OLD) : 8'(LINE_MAX_NEW);
    wire rx_lf = rx_valid & (rx_data == CH_LF);
    wire rx_cr = rx_valid & (rx_data == CH_CR);
    wire rx_bs = rx_valid & (rx_data == CH_BS);
    wire rx_norm = rx_valid & ~rx_lf & ~rx_cr & ~rx_bs;
    wire rx_fits = (len_q < line_max) & ~ovf_q;
    wire push_v = end_pend_q | ((rx_norm & rx_fits) | rx_cr) & hold_v_q;
    wire [7:0] push_d = end_pend_q ? end_byte_q : hold_q;
    logic f_in_ready, f_out_valid, f_out_ready;
    logic [LW-1:0] f_level;
    logic [7:0] f_out_data;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hold_q <= '0;
            hold_v_q <= 1'b0;
            end_pend_q <= 1'b0;
            end_byte_q <= '0;
            len_q <= '0;
            ovf_q <= 1'b0;
        end else if (ce_i) begin
            end_pend_q <= 1'b0;
            if (rx_cr) begin
                // an overlong line ends in a cancel byte instead
                end_pend_q <= 1'b1;
                end_byte_q <= ovf_q ? CH_CAN : CH_CR;
                hold_v_q <= 1'b0;
                len_q <= '0;
                ovf_q <= 1'b0;
            end else if (rx_bs && hold_v_q) begin
                hold_v_q <= 1'b0;
                len_q <= len_q - 8'd1;
            end else if (rx_norm && !rx_fits) begin
                ovf_q <= 1'b1;
            end else if (rx_norm) begin
                hold_q <= rx_data;
                hold_v_q <= 1'b1;
                len_q <= len_q + 8'd1;
            end
        end
    end
    // a line feed is dropped, so cr-only lines work as well

    rsc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .in_valid_i(push_v),
        .in_data_i(push_d),
        .in_ready_o(f_in_ready),
        .level_o(f_level),
        .out_valid_o(f_out_valid),
        .out_data_o(f_out_data),
        .out_ready_i(f_out_ready)
    );

    // parser: stalls while a decoded command waits for the rack logic
    rsc_parse_type ps_q;
    logic [7:0] num_q, addr_q, chan_q, letter_q;
    logic has_addr_q, sel_v_q, query_q;
    logic [4:0] unit_addr_q;
    assign f_out_ready = ~cmd_valid_o;
    wire take = f_out_valid & f_out_ready;
    wire [7:0] c = to_upper(f_out_data);
    wire c_dig = is_digit(c);
    wire c_end = (c == CH_CR) | (c == CH_SEMI);
    localparam logic [7:0] CH_UP_A_MIN = CH_LO_A & ~CH_CASE;
    localparam logic [7:0] CH_UP_Z_MAX = CH_LO_Z & ~CH_CASE;
    wire c_can = (c == CH_CAN);
    wire c_letter = (c >= CH_UP_A_MIN) & (c <= CH_UP_Z_MAX);
    wire emit = take & c_end & (ps_q != PS_ADDR);
    wire is_global = has_addr_q & (addr_q == 8'(ADDR_GLOBAL));
    wire addr_hit = ~has_addr_q | is_global
                  | (addr_q == 8'(unit_addr_q));
    wire [7:0] cur_chan = (ps_q == PS_CHAN) ? num_q : chan_q;
    wire [7:0] cur_sel = (ps_q == PS_SEL) ? num_q : 8'h00;
    wire cur_sel_v = (ps_q == PS_SEL) & sel_v_q;
    wire hit = emit & addr_hit;
    wire sel_in_range = (cur_sel >= 8'(ADDR_MIN)) & (cur_sel <= 8'(ADDR_MAX));
    wire do_addr = hit & (letter_q == CH_UP_U) & cur_sel_v & sel_in_range;
    wire flash_go = hit & (letter_q == CH_UP_L) & cur_sel_v
                  & (cur_sel == 8'(LED_SEL_TEST));

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ps_q <= PS_ADDR;
            num_q <= '0;
            addr_q <= '0;
            chan_q <= '0;
            letter_q <= '0;
            has_addr_q <= 1'b0;
            sel_v_q <= 1'b0;
            query_q <= 1'b0;
        end else if (ce_i && take) begin
            if (c_can || c_end) begin
                // every segment carries its own address, if any
                ps_q <= PS_ADDR;
                num_q <= '0;
                has_addr_q <= 1'b0;
                sel_v_q <= 1'b0;
                query_q <= 1'b0;
            end else if (c_dig) begin
                num_q <= dec_step(num_q, c);
                sel_v_q <= sel_v_q | (ps_q == PS_SEL);
            end else if (ps_q == PS_ADDR && c == CH_COLON) begin
                addr_q <= num_q;
                has_addr_q <= 1'b1;
                num_q <= '0;
            end else if (ps_q == PS_ADDR && (c_letter || c == CH_QM)) begin
                letter_q <= c;
                num_q <= '0;
                ps_q <= PS_CHAN;
            end else if (ps_q == PS_CHAN && (c == CH_EQ || c == CH_QM)) begin
                chan_q <= num_q;
                num_q <= '0;
                query_q <= (c == CH_QM);
                ps_q <= PS_SEL;
            end
        end
    end

    // decoded command towards the rack logic
    logic reply_en_q;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cmd_valid_o <= 1'b0;
            cmd_letter_o <= '0;
            cmd_chan_o <= '0;
            cmd_sel_o <= '0;
            cmd_sel_valid_o <= 1'b0;
            cmd_query_o <= 1'b0;
            cmd_global_o <= 1'b0;
            reply_en_q <= 1'b0;
        end else if (ce_i) begin
            if (hit) begin
                cmd_valid_o <= 1'b1;
                cmd_letter_o <= letter_q;
                cmd_chan_o <= cur_chan;
                cmd_sel_o <= cur_sel;
                cmd_sel_valid_o <= cur_sel_v;
                cmd_query_o <= query_q;
                cmd_global_o <= is_global;
                // only rack one answers a global command
                reply_en_q <= ~is_global | (unit_addr_q == 5'(ADDR_TALKER));
            end else if (cmd_ready_i) begin
                cmd_valid_o <= 1'b0;
            end
        end
    end

    // addresses: the nonvolatile copy is reloaded on every reset, which
    // also discards a front-panel entry; only reset_i restarts the block
    logic [1:0] init_q;
    logic nv_wr_q;
    logic [3:0] bus_addr_q;
    wire init_cap = (init_q == 2'd1);
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            init_q <= 2'(INIT_WAIT);
            unit_addr_q <= 5'(ADDR_MIN);
            bus_addr_q <= 4'(BUS_ADDR_MIN);
            nv_wr_q <= 1'b0;
        end else if (ce_i) begin
            nv_wr_q <= 1'b0;
            if (init_q != 2'd0) begin
                init_q <= init_q - 2'd1;
            end
            if (init_cap) begin
                unit_addr_q <= nv_addr_i;
                // switch zero is out of range and falls back to one
                bus_addr_q <= (sw_s2_q == 4'd0) ? 4'(BUS_ADDR_MIN)
                                                : sw_s2_q;
            end else if (do_addr) begin
                unit_addr_q <= cur_sel[4:0];
                nv_wr_q <= 1'b1;
            end else if (panel_addr_we_i) begin
                unit_addr_q <= panel_addr_i;
            end
        end
    end
    assign unit_addr_o = unit_addr_q;
    assign nv_wr_o = nv_wr_q;
    assign bus_addr_o = bus_addr_q;

    // led flasher: six phases, on-off three times
    logic [2:0] flash_left_q;
    logic [31:0] flash_cnt_q;
    logic led_q;
    wire flash_tick = (flash_cnt_q == '0);
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flash_left_q <= 3'(FLASH_PHASES);
            flash_cnt_q <= 32'(FLASH_CYCLES - 1);
            led_q <= 1'b0;
        end else if (ce_i) begin
            if (flash_go) begin
                flash_left_q <= 3'(FLASH_PHASES);
                flash_cnt_q <= 32'(FLASH_CYCLES - 1);
            end else if (flash_left_q != 3'd0) begin
                flash_cnt_q <= flash_tick ? 32'(FLASH_CYCLES - 1)
                                          : flash_cnt_q - 32'd1;
                if (flash_tick) begin
                    flash_left_q <= flash_left_q - 3'd1;
                end
            end
            led_q <= (flash_left_q != 3'd0) & ~flash_left_q[0];
        end
    end
    assign led_flash_o = led_q;

    // transmitter: only response bytes are sent, never received ones
    logic tx_busy_q, txd_q, resp_ready_q, eoi_q, rts_q;
    logic [FRAME_BITS-1:0] tx_sh_q;
    logic [3:0] tx_bit_q;
    logic [15:0] tx_cnt_q;
    wire cts_s = cts_s2_q;
    wire tx_take = resp_valid_i & resp_ready_q
                 & (cts_s | ~reply_en_q);
    wire tx_start = tx_take & reply_en_q;
    wire tx_tick = (tx_cnt_q == '0);
    wire tx_last = tx_tick & (tx_bit_q == 4'(FRAME_BITS - 1));
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_busy_q <= 1'b0;
            txd_q <= 1'b1;
            tx_sh_q <= '1;
            tx_bit_q <= '0;
            tx_cnt_q <= '0;
            resp_ready_q <= 1'b0;
            eoi_q <= 1'b0;
            rts_q <= 1'b0;
        end else if (ce_i) begin
            // the far end sees rts drop while two places remain free
            rts_q <= f_level < LW'(FIFO_DEPTH - FIFO_SLACK);
            resp_ready_q <= ~tx_busy_q & ~tx_take & ~tx_start;
            if (tx_start) begin
                tx_busy_q <= 1'b1;
                tx_sh_q <= {1'b1, resp_data_i, 1'b0};
                txd_q <= 1'b0;
                tx_bit_q <= '0;
                tx_cnt_q <= 16'(BIT_CYCLES - 1);
                eoi_q <= resp_last_i;
            end else if (tx_busy_q) begin
                tx_cnt_q <= tx_tick ? 16'(BIT_CYCLES - 1) : tx_cnt_q - 16'd1;
                if (tx_last) begin
                    tx_busy_q <= 1'b0;
                    eoi_q <= 1'b0;
                    txd_q <= 1'b1;
                end else if (tx_tick) begin
                    tx_bit_q <= tx_bit_q + 4'd1;
                    tx_sh_q <= {1'b1, tx_sh_q[FRAME_BITS-1:1]};
                    txd_q <= tx_sh_q[1];
                end
            end
        end
    end
    assign txd_o = txd_q;
    assign rts_o = rts_q;
    assign resp_ready_o = resp_ready_q;
    assign eoi_o = eoi_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    tx_waits_cts_a: assert property ($rose(tx_busy_q) |-> $past(cts_s))
        else $error("frame started without clear to send");
    tx_start_bit_a: assert property ($rose(tx_busy_q) |-> !txd_q)
        else $error("frame does not open with a start bit");
    reply_gate_a: assert property ($rose(tx_busy_q) |-> reply_en_q)
        else $error("reply sent by a rack that must stay silent");
    global_talker_a: assert property (ce_i && hit && is_global
        |=> reply_en_q == ($past(unit_addr_q) == 5'(ADDR_TALKER)))
        else $error("global reply enable not tied to rack one");
    nv_range_a: assert property (nv_wr_q |->
        unit_addr_q >= 5'(ADDR_MIN) && unit_addr_q <= 5'(ADDR_MAX))
        else $error("stored address out of range");
    nv_source_a: assert property (nv_wr_q |->
        cmd_valid_o && cmd_letter_o == CH_UP_U && cmd_sel_o[4:0] == unit_addr_q)
        else $error("persistent write not caused by address command");
    line_len_a: assert property (len_q <= line_max)
        else $error("line length beyond limit");
    upper_letter_a: assert property (cmd_valid_o |->
        !(cmd_letter_o >= CH_LO_A && cmd_letter_o <= CH_LO_Z))
        else $error("command letter left in lower case");
    flash_restart_a: assert property (ce_i && flash_go
        |=> flash_left_q == 3'(FLASH_PHASES) ##1 led_q)
        else $error("led test did not restart the flasher");
endmodule

// file: core/rsc_pkg.sv
// constants, types and helpers shared by the rack serial command link.
// assumes a 125 MHz system clock; the bit and flash cycle counts derive from it here.
package rsc_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int BAUD = 9600;
    localparam int BIT_CYC = CLK_HZ / BAUD;
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 1;
    localparam int FRAME_BITS = 1 + DATA_BITS + STOP_BITS;
    localparam int FLASH_MS = 200;
    localparam int FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
    localparam int FLASH_PHASES = 6;
    localparam int LINE_MAX_NEW = 150;
    localparam int LINE_MAX_OLD = 64;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_SLACK = 2;
    localparam int INIT_WAIT = 3;
    localparam int ADDR_GLOBAL = 0;
    localparam int ADDR_MIN = 1;
    localparam int ADDR_MAX = 16;
    localparam int ADDR_TALKER = 1;
    localparam int BUS_ADDR_MIN = 1;
    localparam int LED_SEL_TEST = 1;
    localparam logic [7:0] CH_BS = 8'h08;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_CAN = 8'h18;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_9 = 8'h39;
    localparam logic [7:0] CH_COLON = 8'h3A;
    localparam logic [7:0] CH_SEMI = 8'h3B;
    localparam logic [7:0] CH_EQ = 8'h3D;
    localparam logic [7:0] CH_QM = 8'h3F;
    localparam logic [7:0] CH_UP_L = 8'h4C;
    localparam logic [7:0] CH_UP_U = 8'h55;
    localparam logic [7:0] CH_LO_A = 8'h61;
    localparam logic [7:0] CH_LO_Z = 8'h7A;
    localparam logic [7:0] CH_CASE = 8'h20;
    localparam logic [7:0] NUM_SAT = 8'hFF;

    typedef enum {PS_ADDR, PS_CHAN, PS_SEL} rsc_parse_type;

    function automatic logic is_digit(input logic [7:0] c);
        return (c >= CH_0) && (c <= CH_9);
    endfunction

    function automatic logic [7:0] to_upper(input logic [7:0] c);
        return ((c >= CH_LO_A) && (c <= CH_LO_Z)) ? (c & ~CH_CASE) : c;
    endfunction

    // decimal accumulate, saturating so long digit runs never wrap
    function automatic logic [7:0] dec_step(input logic [7:0] n,
                                            input logic [7:0] c);
        logic [11:0] t;
        t = 12'(n) * 12'd10 + 12'(c - CH_0);
        return (t > 12'(NUM_SAT)) ? NUM_SAT : t[7:0];
    endfunction
endpackage

// file: core/rsc_uart_rx.sv
// 8n1 receiver; rxd_i must already be synchronised to clk_i.
// a byte with a bad stop bit is dropped without a pulse.
`timescale 1ns/1ps
module rsc_uart_rx #(
    parameter int BIT_CYCLES = rsc_pkg::BIT_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic rxd_i,
    output logic [7:0] data_o,
    output logic valid_o
);
    import rsc_pkg::*;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rsc_rx_type;
    rsc_rx_type st_q;
    logic [15:0] cnt_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    wire tick = (cnt_q == '0);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_q <= RX_IDLE;
            cnt_q <= '0;
            bit_q <= '0;
            sh_q <= '0;
            data_o <= '0;
            valid_o <= 1'b0;
        end else if (ce_i) begin
            valid_o <= 1'b0;
            cnt_q <= tick ? 16'(BIT_CYCLES - 1) : cnt_q - 16'd1;
            unique case (st_q)
                RX_IDLE: begin
                    cnt_q <= 16'(BIT_CYCLES / 2);
                    if (!rxd_i) begin
                        st_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (tick) begin
                        st_q <= rxd_i ? RX_IDLE : RX_DATA;
                        bit_q <= '0;
                    end
                end
                RX_DATA: begin
                    if (tick) begin
                        sh_q <= {rxd_i, sh_q[7:1]};
                        bit_q <= bit_q + 3'd1;
                        if (bit_q == 3'(DATA_BITS - 1)) begin
                            st_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (tick) begin
                        st_q <= RX_IDLE;
                        valid_o <= rxd_i;
                        data_o <= sh_q;
                    end
                end
            endcase
        end
    end
endmodule

// file: verif/rsc_host_mdl.sv
// host model: 8n1 serial sender that also grants clear-to-send.
// assumes the bench calls tx from one process at a time.
`timescale 1ns/1ps
module rsc_host_mdl #(
    parameter int BIT_CYCLES = 16
) (
    input wire logic clk_i,
    input wire logic rts_i,
    output logic txd_o,
    output logic cts_o
);
    initial begin
        txd_o = 1'b1;
        cts_o = 1'b1;
    end
    // start low, data lsb first, one stop; line idles high
    task automatic tx(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        // hold the byte back while the link cannot take it
        while (rts_i !== 1'b1) begin
            @(posedge clk_i);
        end
        for (int k = 0; k < 10; k++) begin
            @(posedge clk_i);
            txd_o <= f[k];
            repeat (BIT_CYCLES - 1) @(posedge clk_i);
        end
    endtask
endmodule

// file: verif/tb_top.sv
// bench for the rack serial command link: lines in, commands out, replies.
// assumes the host model drives rxd_i and cts_i.
`timescale 1ns/1ps
module tb_top;
    localparam int BC = 16;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic ce_i = 1'b1;
    logic old_fw_i = 1'b0;
    logic panel_addr_we_i = 1'b0;
    logic cmd_ready_i = 1'b0;
    logic resp_valid_i = 1'b0;
    logic resp_last_i = 1'b0;
    logic [3:0] bus_switch_i = 4'h7;
    logic [4:0] nv_addr_i = 5'h03;
    logic [4:0] panel_addr_i = 5'h09;
    logic [7:0] resp_data_i = 8'h00;
    logic rxd_i, cts_i, txd_o, rts_o, nv_wr_o, cmd_valid_o, cmd_sel_valid_o;
    logic cmd_query_o, cmd_global_o, resp_ready_o, eoi_o, led_flash_o;
    logic [3:0] bus_addr_o;
    logic [4:0] unit_addr_o;
    logic [7:0] cmd_letter_o, cmd_chan_o, cmd_sel_o;
    int mismatches = 0;
    int comparisons = 0;
    int nv_cnt = 0;
    int tx_low = 0;
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (!reset_i) begin
            nv_cnt <= nv_cnt + int'(nv_wr_o === 1'b1);
            tx_low <= tx_low + int'(txd_o !== 1'b1);
        end
        // the store keeps what the link writes, as a real one would
        if (nv_wr_o === 1'b1) begin
            nv_addr_i <= unit_addr_o;
        end
    end
    rsc_host_mdl #(.BIT_CYCLES(BC)) i_host (
        .clk_i, .rts_i(rts_o), .txd_o(rxd_i), .cts_o(cts_i));
    rsc_link #(.BIT_CYCLES(BC), .FLASH_CYCLES(200)) i_dut (
        .clk_i, .reset_i, .ce_i, .rxd_i, .cts_i, .txd_o, .rts_o, .old_fw_i,
        .bus_switch_i, .bus_addr_o, .nv_addr_i, .nv_wr_o, .panel_addr_i,
        .panel_addr_we_i, .unit_addr_o, .cmd_valid_o, .cmd_ready_i,
        .cmd_letter_o, .cmd_chan_o, .cmd_sel_o, .cmd_sel_valid_o,
        .cmd_query_o, .cmd_global_o, .resp_valid_i, .resp_data_i,
        .resp_last_i, .resp_ready_o, .eoi_o, .led_flash_o);
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %0t saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic line(input string s);
        foreach (s[i]) i_host.tx(s[i]);
    endtask
    // wait for a decoded command, judge it, then accept it
    task automatic cmd(input logic [7:0] l, c, s, input logic g, q);
        int i;
        i = 0;
        // step off the edge so a command just dropped is not seen again
        @(negedge clk_i);
        while (cmd_valid_o !== 1'b1 && i < 300) begin
            @(negedge clk_i);
            i++;
        end
        chk({7'h00, cmd_valid_o}, 8'h01);
        chk({7'h00, cmd_query_o}, {7'h00, q});
        chk({7'h00, cmd_sel_valid_o}, {7'h00, ~q});
        chk(cmd_letter_o, l);
        chk(cmd_chan_o, c);
        chk(cmd_sel_o, s);
        chk({7'h00, cmd_global_o}, {7'h00, g});
        @(posedge clk_i);
        cmd_ready_i <= 1'b1;
        @(posedge clk_i);
        cmd_ready_i <= 1'b0;
    endtask
    // offer one final reply byte; f says whether a frame must go out
    task automatic resp(input logic [7:0] d, input logic f);
        logic [9:0] fr;
        int i;
        fr = {1'b1, d, 1'b0};
        i = 0;
        @(posedge clk_i);
        resp_data_i <= d;
        resp_last_i <= 1'b1;
        resp_valid_i <= 1'b1;
        @(negedge clk_i);
        while (resp_ready_o !== 1'b1 && i < 300) begin
            @(negedge clk_i);
            i++;
        end
        chk({7'h00, resp_ready_o}, 8'h01);
        @(posedge clk_i);
        resp_valid_i <= 1'b0;
        repeat (BC / 2) @(negedge clk_i);
        chk({7'h00, eoi_o}, {7'h00, f});
        for (int k = 0; k < 10; k++) begin
            chk({7'h00, txd_o}, {7'h00, f ? fr[k] : 1'b1});
            repeat (BC) @(negedge clk_i);
        end
    endtask
    initial begin
        repeat (30000) @(posedge clk_i);
        mismatches++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        chk({3'h0, unit_addr_o}, 8'h01);
        reset_i <= 1'b0;
        repeat (4) @(negedge clk_i);
        chk({3'h0, unit_addr_o}, 8'h03);
        chk({4'h0, bus_addr_o}, 8'h07);
        chk({7'h00, led_flash_o}, 8'h01);
        line("l4\0103=1\015\012");
        cmd("L", 8'h03, 8'h01, 1'b0, 1'b0);
        chk({7'h00, led_flash_o}, 8'h01);
        chk(8'(tx_low), 8'h00);
        line("00:u=5\015");
        cmd("U", 8'h00, 8'h05, 1'b1, 1'b0);
        repeat (2) @(negedge clk_i);
        chk({3'h0, unit_addr_o}, 8'h05);
        chk(8'(nv_cnt), 8'h01);
        resp(8'h41, 1'b0);
        line("5:s1?\015\012");
        cmd("S", 8'h01, 8'h00, 1'b0, 1'b1);
        resp(8'h5A, 1'b1);
        line("0:l2=1; 0:x7=3\015\012");
        cmd("L", 8'h02, 8'h01, 1'b1, 1'b0);
        cmd("X", 8'h07, 8'h03, 1'b1, 1'b0);
        // a panel address is lost on reset, a remote one is kept
        @(posedge clk_i);
        panel_addr_we_i <= 1'b1;
        @(posedge clk_i);
        panel_addr_we_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        chk({3'h0, unit_addr_o}, 8'h09);
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (4) @(negedge clk_i);
        chk({3'h0, unit_addr_o}, 8'h05);
        chk({7'h00, led_flash_o}, 8'h01);
        chk(8'(nv_cnt), 8'h01);
        test_done();
    end
endmodule
